// ==== hdl/dfs_fault_status.sv ====
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Eight bits show which channels are faulting
// - Manager bit 30 marks debug-sourced instruction
// - Manager bit 16 on bad fetch response
// - Manager bit 5 on non-secure secure-event use
// - Manager bit 4 on non-secure secure launch
// - Manager bits 1/0: invalid operand, undefined instruction
// - Channel bit 31 on resource lock-up, imprecise
// - Channel bit 30 debug source, precise only
// - Channel bit 18 on bad read response
// - Channel bit 17 on bad write response
// - Channel bit 16 on bad fetch, precise
// - Channel bit 13 on store data shortfall
// - Status bit 0 shows manager faulting
module dfs_fault_status #(
  parameter int unsigned NCH = dfs_pkg::NUM_CH
) (
  input  wire logic                             clk,
  input  wire logic                             reset,
  // Avalon-MM slave
  input  wire logic [7:0]                       avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic [31:0]                           avs_readdata,
  output logic                                  avs_waitrequest,
  output logic [1:0]                            avs_response,
  // Abort reports from the instruction engine
  input  wire dfs_pkg::dfs_mgr_abort_t          mgr_abort,
  input  wire logic                             mgr_leave_fault,
  input  wire dfs_pkg::dfs_ch_abort_t [NCH-1:0] ch_abort,
  input  wire logic [NCH-1:0]                   ch_leave_fault,
  input  wire logic [NCH-1:0]                   ch_completing,
  // Status outputs
  output logic [NCH-1:0]                        ch_fault_status,
  output logic                                  manager_faulting_flag,
  output logic                                  irq
);
  import dfs_pkg::*;

  // The channel select and the interrupt layout leave room for eight channels at most
  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("NCH must be 1..8");
  end

  dfs_fault_if mgr_if ();
  dfs_fault_if ch_if [NCH] ();

  logic [NCH-1:0]       ch_faulting;
  logic [NCH-1:0]       ch_new;
  logic [31:0]          ch_type [NCH];
  logic [2:0]           ch_sel_r;
  logic [IRQ_WIDTH-1:0] irq_status_r;
  logic [IRQ_WIDTH-1:0] irq_enable_r;
  logic [IRQ_WIDTH-1:0] irq_events;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic                 ack_r;
  logic [31:0]          rdata_r;
  logic [1:0]           resp_r;
  logic [31:0]          rdata_nxt;
  logic                 mapped;
  logic                 req;

  dfs_mgr_recorder u_mgr (
    .clk         (clk),
    .reset       (reset),
    .abort_in    (mgr_abort),
    .leave_fault (mgr_leave_fault),
    .fault       (mgr_if.recorder)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      dfs_ch_recorder u_ch (
        .clk         (clk),
        .reset       (reset),
        .abort_in    (ch_abort[g]),
        .leave_fault (ch_leave_fault[g]),
        .fault       (ch_if[g].recorder)
      );
      // Faulting-completing keeps the indicator up even once the record is cleared
      assign ch_faulting[g] = ch_if[g].faulting || ch_completing[g];
      assign ch_new[g]      = ch_if[g].abort_new;
      assign ch_type[g]     = ch_if[g].fault_type;
    end
  endgenerate

  assign ch_fault_status       = ch_faulting;
  assign manager_faulting_flag = mgr_if.faulting;

  // Sticky interrupt status; a new event wins over a clear in the same cycle
  assign irq_events = {mgr_if.abort_new, 8'(ch_new)};
  assign req        = (avs_read || avs_write) && !ack_r;
  assign irq_clear  = (req && avs_write && avs_address == OFS_IRQ_CLEAR && avs_byteenable[0])
                      ? {avs_writedata[IRQ_MGR_BIT] && avs_byteenable[1],
                         avs_writedata[7:0]}
                      : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_enable_r <= IRQ_ENABLE_RST[IRQ_WIDTH-1:0];
    end else if (req && avs_write && avs_address == OFS_IRQ_ENABLE) begin
      if (avs_byteenable[0]) irq_enable_r[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) irq_enable_r[IRQ_MGR_BIT] <= avs_writedata[IRQ_MGR_BIT];
    end
  end

  // Channel select picks which channel record the fault-type word shows
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch_sel_r <= 3'h0;
    end else if (req && avs_write && avs_address == OFS_CH_SELECT && avs_byteenable[0]) begin
      ch_sel_r <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_enable_r);
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    mapped    = 1'b1;
    case (avs_address)
      OFS_MGR_FAULT_STATUS: rdata_nxt[0] = mgr_if.faulting;
      OFS_CH_FAULT_STATUS:  rdata_nxt[NCH-1:0] = ch_faulting;
      OFS_MGR_FAULT_TYPE:   rdata_nxt = mgr_if.fault_type;
      OFS_CH_FAULT_TYPE:    rdata_nxt = (32'(ch_sel_r) < NCH) ? ch_type[ch_sel_r] : 32'h0;
      OFS_CH_SELECT:        rdata_nxt[2:0] = ch_sel_r;
      OFS_IRQ_STATUS:       rdata_nxt[IRQ_WIDTH-1:0] = irq_status_r;
      OFS_IRQ_ENABLE:       rdata_nxt[IRQ_WIDTH-1:0] = irq_enable_r;
      OFS_IRQ_CLEAR:        rdata_nxt = 32'h0000_0000;
      default:              mapped = 1'b0;
    endcase
  end

  // One wait cycle per access: request seen, then answered on the next edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'h0;
    end else begin
      ack_r   <= req;
      if (req) begin
        rdata_r <= avs_read ? rdata_nxt : 32'h0000_0000;
        resp_r  <= mapped ? 2'h0 : 2'h3;
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;

endmodule : dfs_fault_status

// ==== hdl/dfs_pkg.sv ====
package dfs_pkg;

  localparam int unsigned NUM_CH = 8;

  // Byte addresses of the register map
  localparam logic [7:0] OFS_MGR_FAULT_STATUS = 8'h30;
  localparam logic [7:0] OFS_CH_FAULT_STATUS  = 8'h34;
  localparam logic [7:0] OFS_MGR_FAULT_TYPE   = 8'h38;
  localparam logic [7:0] OFS_CH_FAULT_TYPE    = 8'h40;
  localparam logic [7:0] OFS_CH_SELECT        = 8'h50;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h54;
  localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h58;
  localparam logic [7:0] OFS_IRQ_CLEAR        = 8'h5C;

  // Manager fault-type field positions
  localparam int unsigned MFT_DBG_INSTR   = 30;
  localparam int unsigned MFT_FETCH_ERR   = 16;
  localparam int unsigned MFT_EVENT_ERR   = 5;
  localparam int unsigned MFT_LAUNCH_ERR  = 4;
  localparam int unsigned MFT_OPERAND_ERR = 1;
  localparam int unsigned MFT_UNDEF_INSTR = 0;

  // Channel fault-type field positions
  localparam int unsigned CFT_LOCKUP_ERR    = 31;
  localparam int unsigned CFT_DBG_INSTR     = 30;
  localparam int unsigned CFT_DATA_RD_ERR   = 18;
  localparam int unsigned CFT_DATA_WR_ERR   = 17;
  localparam int unsigned CFT_FETCH_ERR     = 16;
  localparam int unsigned CFT_STORE_UNDERFL = 13;

  localparam logic [31:0] FAULT_TYPE_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;

  // Interrupt status layout: bit 8 manager fault, bits 7:0 channel faults
  localparam int unsigned IRQ_MGR_BIT = 8;
  localparam int unsigned IRQ_WIDTH   = 9;

  // AXI-style response codes: anything but OKAY is an error
  localparam logic [1:0] RESP_OKAY = 2'h0;

  typedef struct packed {
    logic       debug_src;
    logic [1:0] fetch_resp;
    logic       fetch_done;
    logic       sec_event_err;
    logic       sec_launch_err;
    logic       operand_err;
    logic       undef_instr;
  } dfs_mgr_abort_t;

  typedef struct packed {
    logic       debug_src;
    logic       lockup;
    logic [1:0] read_resp;
    logic       read_done;
    logic [1:0] write_resp;
    logic       write_done;
    logic [1:0] fetch_resp;
    logic       fetch_done;
    logic       store_underfill;
  } dfs_ch_abort_t;

endpackage : dfs_pkg

// ==== hdl/dfs_fault_if.sv ====
`timescale 1ns/100ps
interface dfs_fault_if;
  import dfs_pkg::*;
  logic        faulting;
  logic        abort_new;
  logic [31:0] fault_type;

  modport recorder (output faulting, output abort_new, output fault_type);
  modport reader   (input  faulting, input  abort_new, input  fault_type);
endinterface : dfs_fault_if

// ==== hdl/dfs_mgr_recorder.sv ====
`timescale 1ns/100ps
module dfs_mgr_recorder (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire dfs_pkg::dfs_mgr_abort_t abort_in,
  input  wire logic                    leave_fault,
  dfs_fault_if.recorder                fault
);
  import dfs_pkg::*;

  logic        faulting_r;
  logic [31:0] type_r;
  logic [31:0] type_nxt;
  logic        hit;

  always_comb begin
    type_nxt = FAULT_TYPE_RST;
    type_nxt[MFT_DBG_INSTR]   = abort_in.debug_src;
    type_nxt[MFT_FETCH_ERR]   = abort_in.fetch_done
                                && (abort_in.fetch_resp != RESP_OKAY);
    type_nxt[MFT_EVENT_ERR]   = abort_in.sec_event_err;
    type_nxt[MFT_LAUNCH_ERR]  = abort_in.sec_launch_err;
    type_nxt[MFT_OPERAND_ERR] = abort_in.operand_err;
    type_nxt[MFT_UNDEF_INSTR] = abort_in.undef_instr;
    hit = type_nxt[MFT_FETCH_ERR] || abort_in.sec_event_err || abort_in.sec_launch_err
          || abort_in.operand_err || abort_in.undef_instr;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      faulting_r <= 1'b0;
    end else if (!faulting_r && hit) begin
      faulting_r <= 1'b1;
    end else if (leave_fault) begin
      faulting_r <= 1'b0;
    end
  end

  // First abort wins; later causes do not disturb the record until the fault is left
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      type_r <= FAULT_TYPE_RST;
    end else if (!faulting_r && hit) begin
      type_r <= type_nxt;
    end else if (faulting_r && leave_fault) begin
      type_r <= FAULT_TYPE_RST;
    end
  end

  assign fault.faulting   = faulting_r;
  assign fault.abort_new  = !faulting_r && hit;
  assign fault.fault_type = type_r;

endmodule : dfs_mgr_recorder

// ==== hdl/dfs_ch_recorder.sv ====
`timescale 1ns/100ps
module dfs_ch_recorder (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire dfs_pkg::dfs_ch_abort_t abort_in,
  input  wire logic                   leave_fault,
  dfs_fault_if.recorder               fault
);
  import dfs_pkg::*;

  logic        faulting_r;
  logic [31:0] type_r;
  logic [31:0] type_nxt;
  logic        precise;
  logic        hit;

  always_comb begin
    type_nxt = FAULT_TYPE_RST;
    type_nxt[CFT_LOCKUP_ERR]    = abort_in.lockup;
    type_nxt[CFT_DATA_RD_ERR]   = abort_in.read_done
                                  && (abort_in.read_resp != RESP_OKAY);
    type_nxt[CFT_DATA_WR_ERR]   = abort_in.write_done
                                  && (abort_in.write_resp != RESP_OKAY);
    type_nxt[CFT_FETCH_ERR]     = abort_in.fetch_done
                                  && (abort_in.fetch_resp != RESP_OKAY);
    type_nxt[CFT_STORE_UNDERFL] = abort_in.store_underfill;
    precise = type_nxt[CFT_FETCH_ERR] || type_nxt[CFT_STORE_UNDERFL];
    // Source flag only carries meaning for precise aborts, so it is kept zero otherwise
    type_nxt[CFT_DBG_INSTR]     = precise && abort_in.debug_src;
    hit = precise || type_nxt[CFT_LOCKUP_ERR] || type_nxt[CFT_DATA_RD_ERR]
          || type_nxt[CFT_DATA_WR_ERR];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      faulting_r <= 1'b0;
    end else if (!faulting_r && hit) begin
      faulting_r <= 1'b1;
    end else if (leave_fault) begin
      faulting_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      type_r <= FAULT_TYPE_RST;
    end else if (!faulting_r && hit) begin
      type_r <= type_nxt;
    end else if (faulting_r && leave_fault) begin
      type_r <= FAULT_TYPE_RST;
    end
  end

  assign fault.faulting   = faulting_r;
  assign fault.abort_new  = !faulting_r && hit;
  assign fault.fault_type = type_r;

endmodule : dfs_ch_recorder

// ==== sim/dfs_fault_status_asserts.sv ====
`timescale 1ns/100ps
module dfs_fault_status_asserts #(
  parameter int unsigned NCH = dfs_pkg::NUM_CH
) (
  input wire logic                             clk,
  input wire logic                             reset,
  input wire logic [7:0]                       avs_address,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_readdata,
  input wire logic                             avs_waitrequest,
  input wire logic [1:0]                       avs_response,
  input wire dfs_pkg::dfs_mgr_abort_t          mgr_abort,
  input wire logic                             mgr_leave_fault,
  input wire dfs_pkg::dfs_ch_abort_t [NCH-1:0] ch_abort,
  input wire logic [NCH-1:0]                   ch_leave_fault,
  input wire logic [NCH-1:0]                   ch_fault_status,
  input wire logic                             manager_faulting_flag
);
  import dfs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire rd_done = avs_read && !avs_waitrequest;

  a_mgr_take:
  assert property (!manager_faulting_flag && !mgr_leave_fault && mgr_abort.undef_instr
    |=> manager_faulting_flag) else $error("manager abort not recorded");
  a_mgr_hold:
  assert property (manager_faulting_flag && !mgr_leave_fault |=> manager_faulting_flag)
    else $error("manager fault dropped early");
  a_mgr_leave:
  assert property (manager_faulting_flag && mgr_leave_fault |=> !manager_faulting_flag)
    else $error("manager fault not left");
  a_ch_take:
  assert property (!ch_fault_status[0] && !ch_leave_fault[0] && ch_abort[0].lockup
    |=> ch_fault_status[0]) else $error("channel fault not shown");
  a_idle_nowait:
  assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  a_one_wait:
  assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  a_bad_addr:
  assert property (rd_done && avs_address == 8'h44 |-> avs_response == 2'h3)
    else $error("unmapped read not refused");
  a_mgr_read:
  assert property (rd_done && avs_address == OFS_MGR_FAULT_STATUS
    |-> avs_readdata == {31'h0, $past(manager_faulting_flag)}) else $error("bad flag read");
  a_ch_read:
  assert property (rd_done && avs_address == OFS_CH_FAULT_STATUS
    |-> avs_readdata == 32'($past(ch_fault_status))) else $error("bad status read");
endmodule : dfs_fault_status_asserts

bind dfs_fault_status dfs_fault_status_asserts #(.NCH(NCH)) u_dfs_fault_status_asserts (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .mgr_abort(mgr_abort), .mgr_leave_fault(mgr_leave_fault),
  .ch_abort(ch_abort), .ch_leave_fault(ch_leave_fault), .ch_fault_status(ch_fault_status),
  .manager_faulting_flag(manager_faulting_flag));

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import dfs_pkg::*;
  logic                clk, reset, avs_read, avs_write, avs_waitrequest;
  logic                mgr_leave_fault, manager_faulting_flag, irq;
  logic [7:0]          avs_address, ch_leave_fault, ch_completing, ch_fault_status;
  logic [31:0]         avs_writedata, avs_readdata, q;
  logic [3:0]          avs_byteenable;
  logic [1:0]          avs_response, r;
  dfs_mgr_abort_t      mgr_abort;
  dfs_ch_abort_t [7:0] ch_abort;
  int                  bad_count = 0;
  int                  checked = 0;

  dfs_fault_status #(.NCH(8)) u_dfs_fault_status (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .mgr_abort(mgr_abort), .mgr_leave_fault(mgr_leave_fault),
    .ch_abort(ch_abort), .ch_leave_fault(ch_leave_fault), .ch_completing(ch_completing),
    .ch_fault_status(ch_fault_status), .manager_faulting_flag(manager_faulting_flag),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Request stands until waitrequest is seen low at a rising edge; the answer is taken there
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task chk_irq(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  task mgr_pulse(input dfs_mgr_abort_t v);
    @(posedge clk);
    mgr_abort <= v;
    @(posedge clk);
    mgr_abort <= '0;
  endtask : mgr_pulse

  task mgr_leave;
    @(posedge clk);
    mgr_leave_fault <= 1'b1;
    @(posedge clk);
    mgr_leave_fault <= 1'b0;
  endtask : mgr_leave

  // A second cause while faulting must leave the first record untouched
  task mgr_case(input dfs_mgr_abort_t v, input logic [31:0] e);
    mgr_pulse(v);
    rd(OFS_MGR_FAULT_STATUS, {31'h0, e != 32'h0});
    chk({31'h0, manager_faulting_flag}, {31'h0, e != 32'h0});
    rd(OFS_MGR_FAULT_TYPE, e);
    mgr_pulse(8'h08);
    rd(OFS_MGR_FAULT_TYPE, (e == 32'h0) ? 32'h20 : e);
    mgr_leave;
    rd(OFS_MGR_FAULT_TYPE, 32'h0);
  endtask : mgr_case

  task ch_case(input int c, input dfs_ch_abort_t v, input logic [31:0] e);
    bus(1'b1, OFS_CH_SELECT, c);
    @(posedge clk);
    ch_abort[c] <= v;
    @(posedge clk);
    ch_abort <= '0;
    rd(OFS_CH_FAULT_STATUS, {31'h0, e != 32'h0} << c);
    chk({24'h0, ch_fault_status}, {31'h0, e != 32'h0} << c);
    rd(OFS_CH_FAULT_TYPE, e);
    @(posedge clk);
    ch_leave_fault[c] <= 1'b1;
    @(posedge clk);
    ch_leave_fault <= 8'h0;
    rd(OFS_CH_FAULT_STATUS, 32'h0);
  endtask : ch_case

  // Channel scenarios leave sticky status bits behind, so start from a clean status
  task irq_case(input logic en);
    bus(1'b1, OFS_IRQ_ENABLE, {23'h0, en, 8'h0});
    bus(1'b1, OFS_IRQ_CLEAR, 32'h1FF);
    rd(OFS_IRQ_STATUS, 32'h0);
    mgr_pulse(8'h01);
    mgr_leave;
    chk_irq(en);
    rd(OFS_IRQ_STATUS, 32'h100);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h100);
    rd(OFS_IRQ_STATUS, 32'h0);
    chk_irq(1'b0);
  endtask : irq_case

  task report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    {avs_read, avs_write, mgr_leave_fault} = 3'h0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    mgr_abort = '0;
    ch_abort = '0;
    ch_leave_fault = 8'h0;
    ch_completing = 8'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_MGR_FAULT_STATUS, 32'h0);
    rd(OFS_CH_FAULT_STATUS, 32'h0);
    rd(OFS_MGR_FAULT_TYPE, 32'h0);
    rd(OFS_CH_FAULT_TYPE, 32'h0);
    mgr_case(8'h01, 32'h1);
    mgr_case(8'h02, 32'h2);
    mgr_case(8'h04, 32'h10);
    mgr_case(8'h08, 32'h20);
    mgr_case(8'h10, 32'h0);
    mgr_case(8'h30, 32'h1_0000);
    mgr_case(8'h50, 32'h1_0000);
    mgr_case(8'h70, 32'h1_0000);
    mgr_case(8'h81, 32'h4000_0001);
    ch_case(0, 12'h400, 32'h8000_0000);
    ch_case(7, 12'hC00, 32'h8000_0000);
    ch_case(3, 12'h280, 32'h4_0000);
    ch_case(2, 12'h080, 32'h0);
    ch_case(5, 12'h070, 32'h2_0000);
    ch_case(4, 12'h806, 32'h4001_0000);
    ch_case(6, 12'h001, 32'h2000);
    @(posedge clk);
    ch_completing <= 8'h08;
    rd(OFS_CH_FAULT_STATUS, 32'h8);
    ch_completing <= 8'h0;
    irq_case(1'b1);
    irq_case(1'b0);
    rd(OFS_IRQ_CLEAR, 32'h0);
    bus(1'b1, OFS_MGR_FAULT_TYPE, 32'hFFFF_FFFF);
    rd(OFS_MGR_FAULT_TYPE, 32'h0);
    rd(8'h44, 32'h0);
    chk({30'h0, r}, 32'h3);
    report_and_stop;
  end
endmodule : tb_top
